// File: ebs_boot_select.sv
// Boot image selector: AHB-Lite registers, image choice, decryption and fallback
//
// Operation
// - Selected image is decrypted with the stored key when encrypted, and streamed to configuration.
// - Encrypted-only setting rejects any unencrypted image.
// - Stored key is 128 bits wide.
// - First-only, encrypted-only off: unencrypted first image loads regardless of key.
// - First-only, encrypted-only on: unencrypted first image makes configuration fail.
// - Single-image mode ignores the select pin and loads the first image.
// - Dual mode, plain images, no key: select pin low first, high second.
// - Dual mode, encrypted-only off, key stored: plain second image loads on pin high.
// - Dual, encrypted-only on, keyed first, plain second: first image loads on pin high.
// - Dual, encrypted-only on, wrong key, plain second: configuration fails either way.
// - Dual, pin high, first keyed, second foreign key: first image ends up running.
// - Dual, encrypted-only on, pin high, second keyed: second image loads.
// - Dual mode, first-only off: failure of the first image retries the second.
// - Dual mode, first-only off: failure of the second image retries the first.
// - Image choice depends on encryption settings, first-only setting and select pin.
//
// The register offsets and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module ebs_boot_select (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [1:0] hresp,
	output logic [31:0] hrdata,
	input wire logic image_select_pin,
	output logic flash_rd,
	output logic flash_sector_sel,
	output logic [ebs_pkg::ADDR_BITS-1:0] flash_addr,
	input wire logic [31:0] flash_rdata,
	input wire logic flash_rvalid,
	output logic [31:0] cfg_data,
	output logic cfg_valid,
	output logic user_mode,
	output logic config_fail
);
	typedef struct packed {
		logic ap_valid;
		logic ap_write;
		logic [7:0] ap_addr;
		logic [31:0] rdata;
		logic dual;
		logic enc_only;
		logic first_only;
		logic key_stored;
		logic [ebs_pkg::KEY_BITS-1:0] key;
		ebs_pkg::ebs_state_type state;
		logic image;
		logic retried;
		logic sel_latched;
		logic encrypted;
		logic [ebs_pkg::ADDR_BITS-1:0] idx;
		logic [31:0] sum;
		logic rd;
		logic [31:0] cfg_data;
		logic cfg_valid;
		logic user_mode;
		logic fail;
		logic [7:0] attempts;
	} ebs_state_type;

	ebs_state_type s;
	ebs_state_type next_s;
	logic sel_sync;
	logic [31:0] plain;
	logic start;
	logic att_fail;
	logic can_retry;

	ebs_sync u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.pin(image_select_pin),
		.pin_sync(sel_sync)
	);

	ebs_decrypt u_decrypt (
		.key(s.key),
		.word_index(s.idx),
		.encrypted(s.encrypted),
		.cipher(flash_rdata),
		.plain(plain)
	);

	// A second try only where a second image exists and may be used
	assign can_retry = s.dual && !s.first_only && !s.retried;

	always_comb begin
		next_s = s;
		next_s.cfg_valid = 1'b0;
		start = 1'b0;
		att_fail = 1'b0;
		// Data phase of a write
		if (s.ap_valid && s.ap_write) begin
			if (s.ap_addr == ebs_pkg::A_CTRL) begin
				next_s.dual = hwdata[ebs_pkg::CTRL_DUAL];
				next_s.enc_only = hwdata[ebs_pkg::CTRL_ENC_ONLY];
				next_s.first_only = hwdata[ebs_pkg::CTRL_FIRST_ONLY];
				start = hwdata[ebs_pkg::CTRL_START];
			end else if (s.ap_addr == ebs_pkg::A_KEYCTL) begin
				next_s.key_stored = hwdata[ebs_pkg::KEYCTL_STORED];
			end else if (s.ap_addr == ebs_pkg::A_KEY0) begin
				next_s.key[31:0] = hwdata;
			end else if (s.ap_addr == ebs_pkg::A_KEY1) begin
				next_s.key[63:32] = hwdata;
			end else if (s.ap_addr == ebs_pkg::A_KEY2) begin
				next_s.key[95:64] = hwdata;
			end else if (s.ap_addr == ebs_pkg::A_KEY3) begin
				next_s.key[127:96] = hwdata;
			end
		end
		// Address phase; read data registered so it stands in the data phase
		next_s.ap_valid = hsel && hready && htrans[1] && (hsize == ebs_pkg::HSIZE_WORD);
		next_s.ap_write = hwrite;
		next_s.ap_addr = haddr[7:0];
		if (hsel && hready && htrans[1] && !hwrite) begin
			if (haddr[7:0] == ebs_pkg::A_CTRL) begin
				next_s.rdata = {28'h0, s.first_only, s.enc_only, s.dual, 1'b0};
			end else if (haddr[7:0] == ebs_pkg::A_STATUS) begin
				next_s.rdata = {16'h0, s.attempts, s.retried, s.fail, s.user_mode,
					s.image, 1'b0, s.state};
			end else if (haddr[7:0] == ebs_pkg::A_KEYCTL) begin
				next_s.rdata = {31'h0, s.key_stored};
			end else begin
				// Key words are write-only so the secret never leaves the device
				next_s.rdata = 32'h0000_0000;
			end
		end
		case (s.state)
			ebs_pkg::S_HDR: begin
				if (flash_rvalid) begin
					next_s.encrypted = flash_rdata[ebs_pkg::HDR_ENCRYPTED];
					if (!flash_rdata[ebs_pkg::HDR_ENCRYPTED] && s.enc_only) begin
						att_fail = 1'b1;
					end else if (flash_rdata[ebs_pkg::HDR_ENCRYPTED] && !s.key_stored) begin
						att_fail = 1'b1;
					end else begin
						// Plain images pass even with a key stored
						next_s.state = ebs_pkg::S_CHK;
						next_s.idx = ebs_pkg::W_CHECK;
					end
				end
			end
			ebs_pkg::S_CHK: begin
				if (flash_rvalid) begin
					if (plain == ebs_pkg::CHECK_MAGIC) begin
						next_s.state = ebs_pkg::S_DATA;
						next_s.idx = ebs_pkg::W_FIRST_DATA;
						next_s.sum = 32'h0000_0000;
					end else begin
						// Wrong key shows as a bad check word
						att_fail = 1'b1;
					end
				end
			end
			ebs_pkg::S_DATA: begin
				if (flash_rvalid) begin
					if (s.idx != ebs_pkg::W_SUM) begin
						next_s.cfg_data = plain;
						next_s.cfg_valid = 1'b1;
						next_s.sum = s.sum + plain;
						next_s.idx = s.idx + 16'h0001;
					end else if (plain == s.sum) begin
						next_s.state = ebs_pkg::S_DONE;
						next_s.user_mode = 1'b1;
						next_s.rd = 1'b0;
					end else begin
						att_fail = 1'b1;
					end
				end
			end
			default: begin
			end
		endcase
		if (att_fail) begin
			if (can_retry) begin
				next_s.image = ~s.image;
				next_s.retried = 1'b1;
				next_s.state = ebs_pkg::S_HDR;
				next_s.idx = ebs_pkg::W_HEADER;
				next_s.encrypted = 1'b0;
			end else begin
				next_s.state = ebs_pkg::S_FAIL;
				next_s.fail = 1'b1;
				next_s.user_mode = 1'b0;
				next_s.rd = 1'b0;
			end
		end
		// A start request restarts loading even mid-load
		if (start) begin
			next_s.state = ebs_pkg::S_HDR;
			next_s.sel_latched = sel_sync;
			// Mode bits written with the start bit must already count
			next_s.image = (next_s.dual && !next_s.first_only) ? sel_sync : 1'b0;
			next_s.retried = 1'b0;
			next_s.encrypted = 1'b0;
			next_s.idx = ebs_pkg::W_HEADER;
			next_s.rd = 1'b1;
			next_s.user_mode = 1'b0;
			next_s.fail = 1'b0;
			next_s.attempts = s.attempts + 8'h01;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
			s.dual <= ebs_pkg::RST_DUAL;
			s.enc_only <= ebs_pkg::RST_ENC_ONLY;
			s.first_only <= ebs_pkg::RST_FIRST_ONLY;
			s.key_stored <= ebs_pkg::RST_KEY_STORED;
			s.key <= ebs_pkg::RST_KEY;
			s.state <= ebs_pkg::S_IDLE;
		end else begin
			s <= next_s;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = ebs_pkg::HRESP_OKAY;
	assign hrdata = s.rdata;
	assign flash_rd = s.rd;
	assign flash_sector_sel = s.image;
	assign flash_addr = s.idx;
	assign cfg_data = s.cfg_data;
	assign cfg_valid = s.cfg_valid;
	assign user_mode = s.user_mode;
	assign config_fail = s.fail;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence s_attempt_fails;
		att_fail && !start;
	endsequence

	sequence s_retry_other(logic img);
		s.state == ebs_pkg::S_HDR && s.image == !img && s.retried && s.idx == ebs_pkg::W_HEADER;
	endsequence

	property p_retry;
		logic img;
		(s_attempt_fails, img = s.image) ##0 can_retry |=> s_retry_other(img);
	endproperty

	a_retry_other_image: assert property (p_retry)
		else $error("failed image did not retry the other one");

	a_final_fail_flag: assert property (s_attempt_fails ##0 !can_retry
		|=> config_fail && !user_mode && !flash_rd && s.state == ebs_pkg::S_FAIL)
		else $error("exhausted images did not report failure");

	a_fail_no_user: assert property (config_fail |-> !user_mode)
		else $error("user mode together with failure");

	a_enc_only_reject: assert property (s.state == ebs_pkg::S_HDR && flash_rvalid && s.enc_only
		&& !flash_rdata[ebs_pkg::HDR_ENCRYPTED] && !start |=> s.state != ebs_pkg::S_CHK)
		else $error("plain image accepted in encrypted-only mode");

	a_plain_accept: assert property (s.state == ebs_pkg::S_HDR && flash_rvalid && !s.enc_only
		&& !flash_rdata[ebs_pkg::HDR_ENCRYPTED] && !start |=> s.state == ebs_pkg::S_CHK)
		else $error("plain image refused with encrypted-only off");

	a_single_first: assert property (start && (!next_s.dual || next_s.first_only)
		|=> !flash_sector_sel && flash_rd && flash_addr == ebs_pkg::W_HEADER)
		else $error("single or first-only mode did not start on first image");

	a_pin_chooses: assert property (start && next_s.dual && !next_s.first_only
		|=> flash_sector_sel == $past(sel_sync) && !s.retried)
		else $error("select pin did not choose the first image tried");

	a_decrypt_out: assert property (s.state == ebs_pkg::S_DATA && flash_rvalid && !start
		&& s.idx != ebs_pkg::W_SUM |=> cfg_valid && cfg_data == $past(plain))
		else $error("decrypted word not delivered");

	a_user_after_sum: assert property ($rose(user_mode)
		|-> $past(s.state) == ebs_pkg::S_DATA && $past(s.idx) == ebs_pkg::W_SUM)
		else $error("user mode entered without a complete image");

	a_key_check: assert property (s.state == ebs_pkg::S_CHK && flash_rvalid && !start
		&& plain != ebs_pkg::CHECK_MAGIC |-> att_fail)
		else $error("wrong key not detected");
endmodule : ebs_boot_select

// File: ebs_decrypt.sv
// Keystream decryption of one stored image word
`timescale 1ns/1ps
module ebs_decrypt (
	input wire logic [ebs_pkg::KEY_BITS-1:0] key,
	input wire logic [ebs_pkg::ADDR_BITS-1:0] word_index,
	input wire logic encrypted,
	input wire logic [31:0] cipher,
	output logic [31:0] plain
);
	// Stream cipher keyed per word; a lightweight stand-in for a block cipher core
	function automatic logic [31:0] keystream(input logic [ebs_pkg::KEY_BITS-1:0] k,
		input logic [ebs_pkg::ADDR_BITS-1:0] idx);
		logic [31:0] w;
		w = k[32*idx[1:0] +: 32];
		return w ^ {idx, ~idx};
	endfunction : keystream
	always_comb begin
		plain = encrypted ? (cipher ^ keystream(key, word_index)) : cipher;
	end
endmodule : ebs_decrypt

// File: ebs_flash_model.sv
// Behavioural model of the configuration flash holding both stored images
`timescale 1ns/1ps
module ebs_flash_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic flash_rd,
	input wire logic flash_sector_sel,
	input wire logic [ebs_pkg::ADDR_BITS-1:0] flash_addr,
	input wire logic [1:0] enc,
	input wire logic [ebs_pkg::KEY_BITS-1:0] key0,
	input wire logic [ebs_pkg::KEY_BITS-1:0] key1,
	input wire logic [1:0] slow,
	output logic [31:0] flash_rdata,
	output logic flash_rvalid
);
	logic [1:0] wait_cnt;
	logic [31:0] last;
	function automatic logic [31:0] plain(input logic sec, input logic [15:0] i);
		logic [31:0] s;
		s = 32'h0;
		if (i == 16'h0001) return ebs_pkg::CHECK_MAGIC;
		if (i < 16'h000F) return {8'hB0, 7'h00, sec, i};
		for (int k = 2; k < 15; k++) s += {8'hB0, 7'h00, sec, k[15:0]};
		return s;
	endfunction : plain
	function automatic logic [31:0] stored(input logic sec, input logic [15:0] i);
		logic [127:0] k;
		k = sec ? key1 : key0;
		if (i == 16'h0000) return {31'h0, enc[sec]};
		if (!enc[sec]) return plain(sec, i);
		return plain(sec, i) ^ k[32*i[1:0]+:32] ^ {i, ~i};
	endfunction : stored
	// One answer per address; a slow count stretches the latency
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flash_rvalid <= 1'b0;
			wait_cnt <= 2'h0;
			last <= 32'h0;
		end else if (flash_rd && !flash_rvalid && wait_cnt == slow) begin
			flash_rvalid <= 1'b1;
			last <= stored(flash_sector_sel, flash_addr);
			wait_cnt <= 2'h0;
		end else begin
			flash_rvalid <= 1'b0;
			wait_cnt <= (flash_rd && !flash_rvalid) ? wait_cnt + 2'h1 : 2'h0;
		end
	end
	// Outside a valid beat the data lines show garbage, not the old word
	assign flash_rdata = flash_rvalid ? last : ~last;
endmodule : ebs_flash_model

// File: ebs_pkg.sv
// Constants, register map and state codes for the boot image selector
package ebs_pkg;
	localparam int KEY_BITS = 128;
	localparam int ADDR_BITS = 16;
	localparam int STATE_BITS = 3;
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STATUS = 8'h04;
	localparam logic [7:0] A_KEYCTL = 8'h08;
	localparam logic [7:0] A_KEY0 = 8'h10;
	localparam logic [7:0] A_KEY1 = 8'h14;
	localparam logic [7:0] A_KEY2 = 8'h18;
	localparam logic [7:0] A_KEY3 = 8'h1C;
	localparam int CTRL_START = 0;
	localparam int CTRL_DUAL = 1;
	localparam int CTRL_ENC_ONLY = 2;
	localparam int CTRL_FIRST_ONLY = 3;
	localparam int KEYCTL_STORED = 0;
	localparam int HDR_ENCRYPTED = 0;
	localparam int ST_IMAGE = 4;
	localparam int ST_USER = 5;
	localparam int ST_FAIL = 6;
	localparam int ST_RETRIED = 7;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [1:0] HRESP_OKAY = 2'h0;
	localparam logic [ADDR_BITS-1:0] IMAGE_WORDS = 16'h0010;
	localparam logic [ADDR_BITS-1:0] W_HEADER = 16'h0000;
	localparam logic [ADDR_BITS-1:0] W_CHECK = 16'h0001;
	localparam logic [ADDR_BITS-1:0] W_FIRST_DATA = 16'h0002;
	localparam logic [ADDR_BITS-1:0] W_SUM = IMAGE_WORDS - 16'h0001;
	localparam logic [31:0] CHECK_MAGIC = 32'h5A3C_96E1;
	localparam logic RST_DUAL = 1'b0;
	localparam logic RST_ENC_ONLY = 1'b0;
	localparam logic RST_FIRST_ONLY = 1'b0;
	localparam logic RST_KEY_STORED = 1'b0;
	localparam logic [KEY_BITS-1:0] RST_KEY = 128'h0;
	typedef enum logic [STATE_BITS-1:0] {
		S_IDLE = 3'h0,
		S_HDR = 3'h1,
		S_CHK = 3'h2,
		S_DATA = 3'h3,
		S_DONE = 3'h4,
		S_FAIL = 3'h5
	} ebs_state_type;
endpackage : ebs_pkg

// File: ebs_sync.sv
// Two-stage synchroniser for the image-select pin
`timescale 1ns/1ps
module ebs_sync (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic pin,
	output logic pin_sync
);
	typedef struct packed {
		logic meta;
		logic sync;
	} ebs_sync_state_type;
	ebs_sync_state_type s;
	ebs_sync_state_type next_s;
	always_comb begin
		next_s.meta = pin;
		next_s.sync = s.meta;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
	assign pin_sync = s.sync;
endmodule : ebs_sync

// File: tb_top.sv
// Testbench for the boot image selector
`timescale 1ns/1ps
module tb_top;
	localparam logic [127:0] KEY_X = 128'h1F2E3D4C_5B6A7988_97A6B5C4_D3E2F10F;
	localparam logic [127:0] KEY_Y = 128'h0F1E2D3C_4B5A6978_8796A5B4_C3D2E1F0;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic pin = 1'b0;
	logic [1:0] enc = 2'h0;
	logic [1:0] slow = 2'h0;
	logic [127:0] key0 = 128'h0;
	logic [127:0] key1 = 128'h0;
	logic hreadyout, flash_rd, sector, flash_rvalid, cfg_valid, user_mode, config_fail;
	logic [1:0] hresp;
	logic [31:0] hrdata, flash_rdata, cfg_data;
	logic [15:0] flash_addr;
	int failures = 0;
	int checks = 0;
	int cycles = 0;
	ebs_boot_select DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(ebs_pkg::HSIZE_WORD), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.image_select_pin(pin), .flash_rd(flash_rd), .flash_sector_sel(sector),
		.flash_addr(flash_addr), .flash_rdata(flash_rdata), .flash_rvalid(flash_rvalid),
		.cfg_data(cfg_data), .cfg_valid(cfg_valid), .user_mode(user_mode),
		.config_fail(config_fail));
	ebs_flash_model flash (.hclk(hclk), .hresetn(hresetn), .flash_rd(flash_rd),
		.flash_sector_sel(sector), .flash_addr(flash_addr), .enc(enc), .key0(key0),
		.key1(key1), .slow(slow), .flash_rdata(flash_rdata), .flash_rvalid(flash_rvalid));
	always #5 hclk = ~hclk;
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : conclude
	// Whole run needs about a thousand cycles; the ceiling leaves ample margin
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			conclude();
		end
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask : ahb
	function automatic logic [31:0] pw(input logic sec, input logic [15:0] i);
		return {8'hB0, 7'h00, sec, i};
	endfunction : pw
	// en/ky: bit per image (encrypted, uses second key); st: 0 none, 1 first key, 2 second
	task automatic run_case(input logic dual, input logic eo, input logic fo,
		input logic [1:0] en, input logic [1:0] ky, input logic [1:0] st, input logic p,
		input logic [1:0] exp);
		logic [127:0] k;
		logic [31:0] q;
		k = (st == 2'h2) ? KEY_Y : KEY_X;
		enc <= en;
		key0 <= ky[0] ? KEY_Y : KEY_X;
		key1 <= ky[1] ? KEY_Y : KEY_X;
		pin <= p;
		slow <= slow + 2'h1;
		for (int w = 0; w < 4; w++) ahb(1'b1, ebs_pkg::A_KEY0 + 8'(4 * w), k[32*w+:32], q);
		ahb(1'b1, ebs_pkg::A_KEYCTL, {31'h0, st != 2'h0}, q);
		ahb(1'b1, ebs_pkg::A_CTRL, {28'h0, fo, eo, dual, 1'b1}, q);
		repeat (3) @(posedge hclk);
		for (int n = 0; n < 400 && user_mode !== 1'b1 && config_fail !== 1'b1; n++)
			@(posedge hclk);
		ahb(1'b0, ebs_pkg::A_STATUS, 32'h0, q);
		cmp({30'h0, config_fail, user_mode}, (exp == 2'h2) ? 32'h2 : 32'h1);
		if (exp != 2'h2) begin
			cmp({31'h0, q[ebs_pkg::ST_IMAGE]}, {31'h0, exp[0]});
			cmp(cfg_data, pw(exp[0], 16'h000E));
		end
	endtask : run_case
	initial begin
		logic [31:0] q;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		ahb(1'b0, ebs_pkg::A_STATUS, 32'h0, q);
		cmp(q, 32'h0);
		ahb(1'b0, 8'h40, 32'h0, q);
		cmp(q, 32'h0);
		cmp({30'h0, hresp}, 32'h0);
		ahb(1'b1, ebs_pkg::A_KEY3, 32'hFFFF_FFFF, q);
		ahb(1'b0, ebs_pkg::A_KEY3, 32'h0, q);
		cmp(q, 32'h0);
		run_case(1'b0, 1'b0, 1'b0, 2'h0, 2'h0, 2'h0, 1'b1, 2'h0);
		run_case(1'b0, 1'b0, 1'b0, 2'h0, 2'h0, 2'h1, 1'b1, 2'h0);
		run_case(1'b1, 1'b0, 1'b1, 2'h0, 2'h0, 2'h2, 1'b1, 2'h0);
		run_case(1'b1, 1'b1, 1'b1, 2'h0, 2'h0, 2'h1, 1'b1, 2'h2);
		run_case(1'b1, 1'b0, 1'b0, 2'h0, 2'h0, 2'h0, 1'b0, 2'h0);
		run_case(1'b1, 1'b0, 1'b0, 2'h0, 2'h0, 2'h0, 1'b1, 2'h1);
		run_case(1'b1, 1'b0, 1'b0, 2'h1, 2'h0, 2'h1, 1'b1, 2'h1);
		run_case(1'b1, 1'b1, 1'b0, 2'h1, 2'h0, 2'h1, 1'b1, 2'h0);
		run_case(1'b1, 1'b1, 1'b0, 2'h1, 2'h0, 2'h2, 1'b0, 2'h2);
		run_case(1'b1, 1'b1, 1'b0, 2'h1, 2'h0, 2'h2, 1'b1, 2'h2);
		run_case(1'b1, 1'b1, 1'b0, 2'h3, 2'h2, 2'h1, 1'b1, 2'h0);
		run_case(1'b1, 1'b1, 1'b0, 2'h3, 2'h0, 2'h1, 1'b1, 2'h1);
		run_case(1'b1, 1'b1, 1'b0, 2'h3, 2'h2, 2'h2, 1'b0, 2'h1);
		run_case(1'b1, 1'b0, 1'b0, 2'h1, 2'h0, 2'h0, 1'b0, 2'h1);
		run_case(1'b0, 1'b1, 1'b0, 2'h1, 2'h0, 2'h1, 1'b0, 2'h0);
		run_case(1'b0, 1'b1, 1'b0, 2'h1, 2'h0, 2'h2, 1'b1, 2'h2);
		conclude();
	end
endmodule : tb_top
